// file: rtl/hub_change_pkg.sv
// Constants shared by the hub status change reporter.
// Assumes a 50 MHz hub clock and a byte-addressed Avalon-MM register bus.
package hub_change_pkg;

	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;

	// Register byte offsets.
	localparam logic [5:0] REG_HUB = 6'h00;
	localparam logic [5:0] REG_CTRL = 6'h04;
	localparam logic [5:0] REG_BITMAP = 6'h08;
	localparam logic [5:0] REG_PORT1 = 6'h10;

	// Hub status register fields.
	localparam int HUB_LOCAL_BIT = 0;
	localparam int HUB_OC_BIT = 1;
	localparam int HUB_C_LOCAL_BIT = 16;
	localparam int HUB_C_OC_BIT = 17;

	// Control and characteristics register fields.
	localparam int CTRL_OCMODE_BIT = 0;
	localparam int CTRL_NPORT_LSB = 8;
	localparam logic CTRL_OCMODE_RESET = 1'b1;

	// Port status register fields.
	localparam int P_CONN = 0;
	localparam int P_EN = 1;
	localparam int P_OC = 3;
	localparam int P_RST = 4;
	localparam int P_PWR = 8;
	localparam int P_LS = 9;
	localparam int P_HS = 10;
	localparam int P_C_CONN = 16;
	localparam int P_C_OC = 19;
	localparam int P_C_RST = 20;
	localparam int P_OFF_CMD = 24;

	// Port reset duration.
	localparam int CLK_HZ = 50_000_000;
	localparam int PORT_RESET_US = 10_000;
	localparam int PORT_RESET_CYCLES = PORT_RESET_US * (CLK_HZ / 1_000_000);

	// Whole bytes needed for the hub bit plus one bit per port.
	function automatic int bitmap_bytes(input int nports);
		return (nports + 8) / 8;
	endfunction

endpackage

// file: rtl/level_sync.sv
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none

module level_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end

endmodule

`default_nettype wire

// file: rtl/hub_change_reporter.sv
// Hub status change reporter: change bits, change bitmap polling, port reset and over-current.
// Assumes an Avalon-MM master on mclk and pins that are asynchronous to mclk.
//
// Summary of operation
// - A status change interrupt endpoint exists beside the default control pipe.
// - A poll with no change bit set is answered with NAK.
// - A poll with any change bit set returns the change bitmap.
// - Change bits stay set until software clears them or hub reset.
// - Every poll reports changes while any change bit remains set.
// - A cleared change is no longer reported, so new changes report afresh.
// - Bitmap bit zero carries the hub-level change.
// - Bitmap comes in whole bytes, at least one; absent ports read zero.
// - Bitmap length is hub bit plus ports, rounded up to a byte.
// - Descriptor and status information are readable at any time.
// - Over-current status is live; its change bit flags a status change.
// - Over-current reporting is per port or hub-wide, per the characteristics.
// - Any over-current powers off every affected port.
// - In per-port mode a sagging port powers off with change set, status clear.
// - Hub-wide over-current powers off all ports, port bits untouched.
// - Device attach is detected and reported as a port change.
// - Port hardware detects device speed during port reset.
// - High speed sets HS only, low speed sets LS, full speed neither.
// - Detach reports a change and returns the port to the repeater.
// - Hub reset leaves every change bit cleared.
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module hub_change_reporter #(
	parameter int NPORTS = 4,
	parameter int RESET_CYCLES = hub_change_pkg::PORT_RESET_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic ep_poll,
	output logic ep_nak,
	output logic ep_valid,
	output logic [7:0] ep_data,
	output logic ep_last,
	input wire logic [NPORTS:1] port_connect,
	input wire logic [NPORTS:1] port_oc,
	input wire logic [NPORTS:1] port_sag,
	input wire logic [NPORTS:1] dev_low_speed,
	input wire logic [NPORTS:1] dev_high_speed,
	input wire logic hub_oc,
	input wire logic local_power_good,
	output logic [NPORTS:1] port_power,
	output logic [NPORTS:1] port_enable,
	output logic [NPORTS:1] port_reset_drive
);

	localparam int NBYTES = hub_change_pkg::bitmap_bytes(NPORTS);
	localparam int NBITS = 8 * NBYTES;
	localparam int SW = 5 * NPORTS + 2;

	typedef enum logic {EP_IDLE, EP_SEND} ep_state_e;
	typedef enum logic {PR_IDLE, PR_RUN} pr_state_e;

	function automatic logic [5:0] port_addr(input int n);
		return hub_change_pkg::REG_PORT1 + 6'(4 * (n - 1));
	endfunction

	////////////////////////////////////////////////////////////////////////////////////////////////////

	logic [SW-1:0] sync_q;
	logic [NPORTS:1] conn_s, oc_s, sag_s, ls_s, hs_s;
	logic hub_oc_s, local_s;

	level_sync #(.W(SW)) u_sync (
		.clk(mclk),
		.rst(rst),
		.d({port_connect, port_oc, port_sag, dev_low_speed, dev_high_speed, hub_oc, local_power_good}),
		.q(sync_q)
	);

	assign {conn_s, oc_s, sag_s, ls_s, hs_s, hub_oc_s, local_s} = sync_q;

	////////////////////////////////////////////////////////////////////////////////////////////////////

	logic wr_ok;
	logic [31:0] wd;
	logic oc_per_port;
	logic [NPORTS:1] c_conn, c_oc, c_rst, conn_prev, oc_prev, sag_prev, port_ls, port_hs;
	logic c_hub_local, c_hub_oc, hub_oc_prev, local_prev;
	logic [NPORTS:1] conn_stat, oc_stat, wr_port, pwr_kill;
	logic hub_wr;
	pr_state_e pr_state;
	logic [31:0] pr_cnt;
	logic [NPORTS:1] pr_done;
	logic [NBITS-1:0] bitmap;
	logic [NBITS-1:0] snap;
	ep_state_e ep_state;
	logic [7:0] ep_idx;
	logic [31:0] next_readdata;

	// A write takes effect at the edge where the master sees waitrequest low.
	assign wr_ok = write && !waitrequest;
	assign hub_wr = wr_ok && address == hub_change_pkg::REG_HUB;

	always_comb
	begin
		for (int b = 0; b < 4; b++)
		begin
			wd[8*b +: 8] = byteenable[b] ? writedata[8*b +: 8] : 8'h00;
		end
	end

	always_comb
	begin
		for (int n = 1; n <= NPORTS; n++)
		begin
			wr_port[n] = wr_ok && address == port_addr(n);
			conn_stat[n] = conn_s[n] && port_power[n];
			oc_stat[n] = oc_per_port && oc_s[n];
			pwr_kill[n] = (oc_per_port && (oc_s[n] || sag_s[n])) || (!oc_per_port && hub_oc_s) || !local_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Bus slave handshake: one wait cycle, then a one-cycle low waitrequest.

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			waitrequest <= 1'b1;
		end
		else if (!waitrequest)
		begin
			waitrequest <= 1'b1;
		end
		else if (read || write)
		begin
			waitrequest <= 1'b0;
		end
	end

	always_comb
	begin
		next_readdata = 32'h0000_0000;
		if (address == hub_change_pkg::REG_HUB)
		begin
			next_readdata[hub_change_pkg::HUB_LOCAL_BIT] = local_s;
			next_readdata[hub_change_pkg::HUB_OC_BIT] = hub_oc_s;
			next_readdata[hub_change_pkg::HUB_C_LOCAL_BIT] = c_hub_local;
			next_readdata[hub_change_pkg::HUB_C_OC_BIT] = c_hub_oc;
		end
		else if (address == hub_change_pkg::REG_CTRL)
		begin
			next_readdata[hub_change_pkg::CTRL_OCMODE_BIT] = oc_per_port;
			next_readdata[hub_change_pkg::CTRL_NPORT_LSB +: 8] = 8'(NPORTS);
		end
		else if (address == hub_change_pkg::REG_BITMAP)
		begin
			next_readdata = 32'(bitmap);
		end
		for (int n = 1; n <= NPORTS; n++)
		begin
			if (address == port_addr(n))
			begin
				next_readdata[hub_change_pkg::P_CONN] = conn_stat[n];
				next_readdata[hub_change_pkg::P_EN] = port_enable[n];
				next_readdata[hub_change_pkg::P_OC] = oc_stat[n];
				next_readdata[hub_change_pkg::P_RST] = port_reset_drive[n];
				next_readdata[hub_change_pkg::P_PWR] = port_power[n];
				next_readdata[hub_change_pkg::P_LS] = port_ls[n];
				next_readdata[hub_change_pkg::P_HS] = port_hs[n];
				next_readdata[hub_change_pkg::P_C_CONN] = c_conn[n];
				next_readdata[hub_change_pkg::P_C_OC] = c_oc[n];
				next_readdata[hub_change_pkg::P_C_RST] = c_rst[n];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			readdata <= 32'h0000_0000;
		end
		else if (read && waitrequest)
		begin
			readdata <= next_readdata;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			oc_per_port <= hub_change_pkg::CTRL_OCMODE_RESET;
		end
		else if (wr_ok && address == hub_change_pkg::REG_CTRL)
		begin
			oc_per_port <= wd[hub_change_pkg::CTRL_OCMODE_BIT];
		end
	end

	// Change detection waits until the synchronisers hold settled pin levels.
	logic [1:0] settle_cnt;
	logic armed;
	assign armed = settle_cnt == 2'h3;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			settle_cnt <= 2'h0;
		end
		else if (!armed)
		begin
			settle_cnt <= settle_cnt + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Hub-level change bits; a new event wins over a clear in the same cycle.

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			hub_oc_prev <= 1'b0;
			local_prev <= 1'b1;
			c_hub_oc <= 1'b0;
			c_hub_local <= 1'b0;
		end
		else
		begin
			hub_oc_prev <= hub_oc_s;
			local_prev <= local_s;
			if (armed && hub_oc_s != hub_oc_prev)
			begin
				c_hub_oc <= 1'b1;
			end
			else if (hub_wr && wd[hub_change_pkg::HUB_C_OC_BIT])
			begin
				c_hub_oc <= 1'b0;
			end
			if (armed && local_s != local_prev)
			begin
				c_hub_local <= 1'b1;
			end
			else if (hub_wr && wd[hub_change_pkg::HUB_C_LOCAL_BIT])
			begin
				c_hub_local <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Per-port status, change bits and power state.

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			conn_prev <= '0;
			oc_prev <= '0;
			sag_prev <= '0;
			c_conn <= '0;
			c_oc <= '0;
			c_rst <= '0;
			port_power <= '0;
			port_enable <= '0;
			port_ls <= '0;
			port_hs <= '0;
		end
		else
		begin
			conn_prev <= conn_stat;
			oc_prev <= oc_stat;
			sag_prev <= sag_s;
			for (int n = 1; n <= NPORTS; n++)
			begin
				if (armed && conn_stat[n] != conn_prev[n])
				begin
					c_conn[n] <= 1'b1;
				end
				else if (wr_port[n] && wd[hub_change_pkg::P_C_CONN])
				begin
					c_conn[n] <= 1'b0;
				end
				if (armed && (oc_stat[n] != oc_prev[n] || (oc_per_port && sag_s[n] && !sag_prev[n] && !oc_s[n])))
				begin
					c_oc[n] <= 1'b1;
				end
				else if (wr_port[n] && wd[hub_change_pkg::P_C_OC])
				begin
					c_oc[n] <= 1'b0;
				end
				if (pr_done[n])
				begin
					c_rst[n] <= 1'b1;
				end
				else if (wr_port[n] && wd[hub_change_pkg::P_C_RST])
				begin
					c_rst[n] <= 1'b0;
				end
				if (pwr_kill[n] || (wr_port[n] && wd[hub_change_pkg::P_OFF_CMD]))
				begin
					port_power[n] <= 1'b0;
				end
				else if (wr_port[n] && wd[hub_change_pkg::P_PWR])
				begin
					port_power[n] <= 1'b1;
				end
				if (pwr_kill[n] || !conn_stat[n])
				begin
					port_enable[n] <= 1'b0;
					port_ls[n] <= 1'b0;
					port_hs[n] <= 1'b0;
				end
				else if (pr_done[n])
				begin
					port_enable[n] <= 1'b1;
					port_ls[n] <= ls_s[n];
					port_hs[n] <= hs_s[n] && !ls_s[n];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Port reset engine: one port at a time, speed sampled at its end.

	logic [NPORTS:1] pr_req;

	always_comb
	begin
		for (int n = 1; n <= NPORTS; n++)
		begin
			pr_req[n] = wr_port[n] && wd[hub_change_pkg::P_RST] && conn_stat[n];
			pr_done[n] = pr_state == PR_RUN && port_reset_drive[n] && pr_cnt == 32'(RESET_CYCLES - 1)
				&& conn_stat[n];
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pr_state <= PR_IDLE;
			pr_cnt <= 32'h0000_0000;
			port_reset_drive <= '0;
		end
		else
		begin
			unique case (pr_state)
				PR_IDLE:
				begin
					pr_cnt <= 32'h0000_0000;
					if (|pr_req)
					begin
						port_reset_drive <= pr_req & ~(pr_req - 1'b1);
						pr_state <= PR_RUN;
					end
				end
				PR_RUN:
				begin
					if (!(|(port_reset_drive & conn_stat)) || pr_cnt == 32'(RESET_CYCLES - 1))
					begin
						port_reset_drive <= '0;
						pr_state <= PR_IDLE;
					end
					else
					begin
						pr_cnt <= pr_cnt + 32'h0000_0001;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Status change endpoint: NAK or the change bitmap, one byte per cycle.

	always_comb
	begin
		bitmap = '0;
		bitmap[0] = c_hub_oc || c_hub_local;
		for (int n = 1; n <= NPORTS; n++)
		begin
			bitmap[n] = c_conn[n] || c_oc[n] || c_rst[n];
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ep_state <= EP_IDLE;
			ep_idx <= 8'h00;
			snap <= '0;
			ep_nak <= 1'b0;
			ep_valid <= 1'b0;
			ep_data <= 8'h00;
			ep_last <= 1'b0;
		end
		else
		begin
			ep_nak <= 1'b0;
			ep_valid <= 1'b0;
			ep_last <= 1'b0;
			unique case (ep_state)
				EP_IDLE:
				begin
					ep_idx <= 8'h00;
					if (ep_poll && !(|bitmap))
					begin
						ep_nak <= 1'b1;
					end
					else if (ep_poll)
					begin
						snap <= bitmap;
						ep_state <= EP_SEND;
					end
				end
				EP_SEND:
				begin
					ep_valid <= 1'b1;
					ep_data <= snap[8*ep_idx +: 8];
					ep_idx <= ep_idx + 8'h01;
					if (ep_idx == 8'(NBYTES - 1))
					begin
						ep_last <= 1'b1;
						ep_state <= EP_IDLE;
					end
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// file: bench/usb_host_poller.sv
// Host controller model that polls the status change endpoint.
// Assumes the reporter answers each poll with a NAK or whole bitmap bytes.
`timescale 1ns/1ns
`default_nettype none
module usb_host_poller (
	input wire logic mclk,
	input wire logic ep_nak,
	input wire logic ep_valid,
	input wire logic ep_last,
	input wire logic [7:0] ep_data,
	output logic ep_poll
);
	initial ep_poll = 1'b0;
	// Raises one poll and gathers the answer; the next poll waits for it.
	task automatic poll(output logic nak, output logic [7:0] d);
		int t;
		nak = 1'b0;
		d = 8'h00;
		t = 0;
		@(posedge mclk);
		ep_poll <= 1'b1;
		@(posedge mclk);
		ep_poll <= 1'b0;
		do
		begin
			@(posedge mclk);
			t++;
			nak = nak | ep_nak;
			if (ep_valid === 1'b1)
				d = ep_data;
		end
		while (ep_nak !== 1'b1 && ep_last !== 1'b1 && t < 8);
	endtask
endmodule
`default_nettype wire

// file: bench/hub_change_sva.sv
// Checker for the hub status change reporter.
// Assumes it is bound to the reporter and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module hub_change_sva #(
	parameter int NPORTS = 4,
	parameter int RESET_CYCLES = 20
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	input wire logic ep_poll,
	input wire logic ep_nak,
	input wire logic ep_valid,
	input wire logic [7:0] ep_data,
	input wire logic ep_last,
	input wire logic [NPORTS:1] port_connect,
	input wire logic [NPORTS:1] port_oc,
	input wire logic [NPORTS:1] port_sag,
	input wire logic hub_oc,
	input wire logic [NPORTS:1] port_power,
	input wire logic [NPORTS:1] port_enable,
	input wire logic [NPORTS:1] port_reset_drive
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	AST_NAK_CAUSE: assert property (ep_nak |-> $past(ep_poll) && !ep_valid)
		else $error("nak without poll");
	AST_DATA_CAUSE: assert property ($rose(ep_valid) |-> $past(ep_poll, 2) || $past(ep_poll, 3))
		else $error("bitmap without poll");
	AST_UNUSED_ZERO: assert property (ep_valid |-> (ep_data >> (NPORTS + 1)) == 8'h00)
		else $error("absent port bit set");
	AST_ONE_BYTE: assert property (ep_valid |-> ep_last ##1 !ep_valid)
		else $error("bitmap too long");
	AST_BUS_ANSWER: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
		else $error("register access not answered");
	AST_OC_OFF: assert property (port_oc[2] [*4] |-> !port_power[2])
		else $error("over-current port still powered");
	AST_SAG_OFF: assert property (port_sag[3] [*4] |-> !port_power[3])
		else $error("sagging port still powered");
	AST_HUB_OC_OFF: assert property (hub_oc [*4] |-> port_power == '0)
		else $error("hub over-current left a port powered");
	AST_RESET_LEN: assert property ($rose(port_reset_drive[1]) |-> port_reset_drive[1] [*8])
		else $error("port reset too short");
	AST_RESET_EN: assert property ($fell(port_reset_drive[1]) && port_connect[1] |-> ##[0:1] port_enable[1])
		else $error("port not enabled after reset");
	AST_DETACH: assert property (!port_connect[1] [*4] |-> !port_enable[1])
		else $error("detached port still enabled");
	cover property (ep_nak);
	cover property (ep_valid && ep_data[1]);
	cover property ($fell(port_reset_drive[1]));
endmodule
bind hub_change_reporter hub_change_sva #(.NPORTS(NPORTS), .RESET_CYCLES(RESET_CYCLES)) i_hub_change_sva (
	.mclk, .rst, .read, .write, .waitrequest, .ep_poll, .ep_nak, .ep_valid, .ep_data, .ep_last,
	.port_connect, .port_oc, .port_sag, .hub_oc, .port_power, .port_enable, .port_reset_drive);
`default_nettype wire

// file: bench/hub_change_reporter_tb.sv
// Self-checking bench for the hub status change reporter.
// Assumes a 50 MHz clock, four ports and a short port reset.
`timescale 1ns/1ns
`default_nettype none
module hub_change_reporter_tb;
	localparam int NP = 4;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [5:0] address = 6'h00;
	logic read = 1'b0, write = 1'b0;
	logic [31:0] writedata = 32'h0, readdata, q;
	logic [3:0] byteenable = 4'hF;
	logic waitrequest, ep_poll, ep_nak, ep_valid, ep_last;
	logic [7:0] ep_data;
	logic [NP:1] port_connect = '0, port_oc = '0, port_sag = '0, dev_low_speed = '0, dev_high_speed = '0, m;
	logic hub_oc = 1'b0, local_power_good = 1'b1;
	logic [NP:1] port_power, port_enable, port_reset_drive;
	int failures = 0, n_checks = 0, k, w;
	hub_change_reporter #(.NPORTS(NP), .RESET_CYCLES(20)) i_hub_change_reporter (.mclk, .rst, .address, .read,
		.write, .writedata, .byteenable, .readdata, .waitrequest, .ep_poll, .ep_nak, .ep_valid, .ep_data,
		.ep_last, .port_connect, .port_oc, .port_sag, .dev_low_speed, .dev_high_speed, .hub_oc,
		.local_power_good, .port_power, .port_enable, .port_reset_drive);
	usb_host_poller i_usb_host_poller (.mclk, .ep_nak, .ep_valid, .ep_last, .ep_data, .ep_poll);
	always #10 mclk = ~mclk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			failures++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge mclk);
		address <= a;
		read <= ~wr;
		write <= wr;
		writedata <= d;
		do
			@(posedge mclk);
		while (waitrequest !== 1'b0 && ++t < 50);
		if (t >= 50)
			failures++;
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// A NAK is expected as 100 hex, a bitmap as its byte.
	task automatic pc(input logic [7:0] e);
		logic nk;
		logic [7:0] d;
		i_usb_host_poller.poll(nk, d);
		chk({nk, d}, (e == 8'h00) ? 32'h100 : {24'h0, e});
	endtask
	function automatic logic [7:0] bmap(input logic h, input logic [NP:1] p);
		return {3'h0, p, h};
	endfunction
	function automatic logic [5:0] pa(input int n);
		return hub_change_pkg::REG_PORT1 + 6'(4 * (n - 1));
	endfunction
	task automatic gap;
		repeat (6) @(posedge mclk);
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		#400000;
		failures++;
		report_and_stop;
	end
	initial
	begin
		void'($urandom(57));
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rd(hub_change_pkg::REG_CTRL, 32'h0000_0401);
		pc(8'h00);
		local_power_good <= 1'b0;
		gap;
		local_power_good <= 1'b1;
		gap;
		pc(8'h01);
		pc(8'h01);
		bus(1'b1, hub_change_pkg::REG_HUB, 32'h0001_0000);
		pc(8'h00);
		rd(6'h3C, 32'h0);
		for (k = 1; k <= NP; k++)
			bus(1'b1, pa(k), 32'h0000_0100);
		$display("test 1 done");
		m = 4'($urandom) | 4'h1;
		port_connect <= m;
		gap;
		pc(bmap(1'b0, m));
		port_connect <= 4'h1;
		gap;
		for (k = 1; k <= NP; k++)
			bus(1'b1, pa(k), 32'h0001_0000);
		pc(8'h00);
		for (k = 0; k < 3; k++)
		begin
			dev_low_speed[1] <= (k == 1);
			dev_high_speed[1] <= (k != 0);
			bus(1'b1, pa(1), 32'h0000_0010);
			repeat (2) @(posedge mclk);
			w = 0;
			do
				@(posedge mclk);
			while (port_reset_drive[1] !== 1'b0 && ++w < 100);
			if (w >= 100)
				failures++;
			repeat (2) @(posedge mclk);
			rd(pa(1), 32'h0010_0103 | ((k == 1) ? 32'h200 : (k == 2) ? 32'h400 : 32'h0));
			bus(1'b1, pa(1), 32'h0010_0000);
		end
		$display("test 2 done");
		port_connect <= 4'h0;
		gap;
		rd(pa(1), 32'h0001_0100);
		pc(8'h02);
		bus(1'b1, pa(1), 32'h0001_0000);
		port_oc[2] <= 1'b1;
		port_sag[3] <= 1'b1;
		gap;
		rd(pa(2), 32'h0008_0008);
		rd(pa(3), 32'h0008_0000);
		pc(8'h0C);
		rd(hub_change_pkg::REG_BITMAP, 32'h0000_000C);
		port_oc <= '0;
		port_sag <= '0;
		gap;
		rd(pa(2), 32'h0008_0000);
		bus(1'b1, pa(2), 32'h0008_0100);
		bus(1'b1, pa(3), 32'h0008_0100);
		pc(8'h00);
		$display("test 3 done");
		bus(1'b1, hub_change_pkg::REG_CTRL, 32'h0);
		hub_oc <= 1'b1;
		gap;
		chk(port_power, 32'h0);
		rd(pa(2), 32'h0);
		rd(hub_change_pkg::REG_HUB, 32'h0002_0003);
		pc(8'h01);
		hub_oc <= 1'b0;
		byteenable <= 4'h3;
		gap;
		bus(1'b1, hub_change_pkg::REG_HUB, 32'h0002_0000);
		byteenable <= 4'hF;
		rd(hub_change_pkg::REG_HUB, 32'h0002_0001);
		bus(1'b1, hub_change_pkg::REG_HUB, 32'h0002_0000);
		pc(8'h00);
		$display("test 4 done");
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		gap;
		rd(hub_change_pkg::REG_CTRL, 32'h0000_0401);
		pc(8'h00);
		$display("test 5 done");
		report_and_stop;
	end
endmodule
`default_nettype wire
